// file: shared/tcu_defs.svh
/*
 Constants of the three-channel maxcount timer: widths, register indices,
 control-bit positions, reset values and the internal clock divider.
 Assumes inclusion by bare name from the package and the design module.
*/
// Behaviour
// - Count advances only while run-enable is set
// - Run-enable written only with gate bit set
// - Gate bit always reads back as zero
// - Request-on-terminal enables interrupt at terminal count
// - Dual compare requests on both A and B
// - Raised request survives later run-enable clear
// - Compare-in-use shows B phase as one
// - Terminal flag set at every compare match
// - Prescale ignored under outside clock; internal clock without prescale divides by four
// - Prescaled timer steps at each Timer2 match
// - Outside clock steps from own input pin
// - Dual compare alternates A then B, clearing
// - Single compare uses only A, ignores B
// - One-shot stops after run, clears run-enable
// - Timer2 has single compare, reduced controls
// - Compare zero counts full sixteen-bit range
// - Count clears to zero at compare match
// - Internal clock steps count every fourth cycle
// - Count register read returns present count
// - All registers reset to zero
// - Output pin shows active compare phase in dual compare; single compare pulses low after each match
`ifndef TCU_DEFS_SVH
`define TCU_DEFS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define TCU_AW 9
`define TCU_DW 32
`define TCU_TW 16
`define TCU_IW 7
`define TCU_NT 3

// ----------------------------------------
// Register indices, byte address is four times
// ----------------------------------------
`define TCU_IX_CNT0 7'h50
`define TCU_IX_CMPA0 7'h52
`define TCU_IX_CMPB0 7'h54
`define TCU_IX_CTL0 7'h56
`define TCU_IX_CNT1 7'h58
`define TCU_IX_CMPA1 7'h5a
`define TCU_IX_CMPB1 7'h5c
`define TCU_IX_CTL1 7'h5e
`define TCU_IX_CNT2 7'h60
`define TCU_IX_CMPA2 7'h62
`define TCU_IX_CTL2 7'h66

// ----------------------------------------
// Control bits
// ----------------------------------------
`define TCU_B_EN 15
`define TCU_B_GATE 14
`define TCU_B_REQ 13
`define TCU_B_RIU 12
`define TCU_B_MC 5
`define TCU_B_RTG 4
`define TCU_B_PRE 3
`define TCU_B_EXT 2
`define TCU_B_ALT 1
`define TCU_B_REPEAT_RUN 0

// ----------------------------------------
// Reset values and divider
// ----------------------------------------
`define TCU_RST16 16'h0000
`define TCU_ONE16 16'h0001
`define TCU_DIVW 2
`define TCU_DIV_ONE 2'h1
`define TCU_DIV_LAST 2'h3

`endif

// file: shared/tcu_pkg.sv
/*
 Types of the three-channel maxcount timer: per-timer state, the whole
 state record, bus phase and the Wishbone request carrier.
 Assumes tcu_defs.svh on the include path.
*/
`include "tcu_defs.svh"
package tcu_pkg;
   // Bus phase, one-hot
   typedef enum logic [1:0] {
      TCU_BP_IDLE = 2'b01,
      TCU_BP_ACK = 2'b10
   } tcu_bus_e;

   // Wishbone request group
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [`TCU_AW-1:0] adr;
      logic [3:0] sel;
      logic [`TCU_DW-1:0] dat;
   } tcu_wbreq_s;

   // One timer
   typedef struct packed {
      logic en;
      logic req;
      logic compare_in_use;
      logic mc;
      logic restart_on_input;
      logic pre;
      logic outside_clock_select;
      logic dual_compare_select;
      logic repeat_run;
      logic tcp;
      logic [`TCU_TW-1:0] cnt;
      logic [`TCU_TW-1:0] cmpa;
      logic [`TCU_TW-1:0] cmpb;
   } tcu_tmr_s;

   // Whole block state
   typedef struct packed {
      tcu_tmr_s [`TCU_NT-1:0] t;
      tcu_bus_e bus;
      logic ack;
      logic [`TCU_DW-1:0] dat;
      logic [`TCU_DIVW-1:0] div;
      logic [1:0] inq;
      logic [`TCU_NT-1:0] irq;
      logic [1:0] tout;
   } tcu_state_s;
endpackage : tcu_pkg

// file: rtl/tcu_timers.sv
/*
 Three 16-bit maxcount timers behind a classic Wishbone slave.
 Assumes synchronous timer inputs and an interrupt controller that
 latches the one-cycle request pulses.
*/
// Our own choice: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "tcu_defs.svh"
module tcu_timers (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Wishbone slave
   input wire tcu_pkg::tcu_wbreq_s wb_req,
   output logic wb_ack_o,
   output logic [`TCU_DW-1:0] wb_dat_o,
   // Timer pins
   input wire logic timer0_input,
   input wire logic timer1_input,
   output logic timer0_output,
   output logic timer1_output,
   // Interrupt request pulses
   output logic [`TCU_NT-1:0] tmr_irq
);

   // ----------------------------------------
   // Register index tables
   // ----------------------------------------
   localparam logic [2:0][`TCU_IW-1:0] IX_CNT =
      {`TCU_IX_CNT2, `TCU_IX_CNT1, `TCU_IX_CNT0};
   localparam logic [2:0][`TCU_IW-1:0] IX_CMPA =
      {`TCU_IX_CMPA2, `TCU_IX_CMPA1, `TCU_IX_CMPA0};
   localparam logic [2:0][`TCU_IW-1:0] IX_CTL =
      {`TCU_IX_CTL2, `TCU_IX_CTL1, `TCU_IX_CTL0};
   localparam logic [1:0][`TCU_IW-1:0] IX_CMPB =
      {`TCU_IX_CMPB1, `TCU_IX_CMPB0};

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge(
      input logic [15:0] old,
      input logic [`TCU_DW-1:0] wd,
      input logic [3:0] sel
   );
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction : merge

   // Control word as software sees it
   function automatic logic [15:0] ctl_rd(
      input tcu_pkg::tcu_tmr_s t
   );
      logic [15:0] r;
      r = `TCU_RST16;
      r[`TCU_B_EN] = t.en;
      r[`TCU_B_REQ] = t.req;
      r[`TCU_B_RIU] = t.compare_in_use;
      r[`TCU_B_MC] = t.mc;
      r[`TCU_B_RTG] = t.restart_on_input;
      r[`TCU_B_PRE] = t.pre;
      r[`TCU_B_EXT] = t.outside_clock_select;
      r[`TCU_B_ALT] = t.dual_compare_select;
      r[`TCU_B_REPEAT_RUN] = t.repeat_run;
      return r;
   endfunction : ctl_rd

   // Count plus one, wrapping
   function automatic logic [15:0] inc(
      input logic [15:0] v
   );
      return v + `TCU_ONE16;
   endfunction : inc

   // ----------------------------------------
   // State
   // ----------------------------------------
   tcu_pkg::tcu_state_s q;
   tcu_pkg::tcu_state_s d;
   logic [`TCU_IW-1:0] idx;
   logic wr_now;
   logic tick4;
   logic [1:0] rise;
   logic [`TCU_NT-1:0] tc;
   logic [`TCU_NT-1:0] tk;
   logic [`TCU_NT-1:0] rst_in;
   logic [2:0][15:0] cmp;
   logic [15:0] w;
   logic [15:0] rd;

   // Decode of the Wishbone request
   assign idx = wb_req.adr[`TCU_AW-1:2];
   assign wr_now = (q.bus == tcu_pkg::TCU_BP_ACK) && wb_req.cyc &&
                   wb_req.stb && wb_req.we;

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      d = q;
      tc = '0;
      tk = '0;
      rst_in = '0;
      cmp = '0;
      w = `TCU_RST16;
      rd = `TCU_RST16;
      d.irq = '0;
      // Divide-by-four enable
      tick4 = (q.div == `TCU_DIV_LAST);
      d.div = q.div + `TCU_DIV_ONE;
      // Input edge detection
      d.inq = {timer1_input, timer0_input};
      rise = {timer1_input, timer0_input} & ~q.inq;

      // Timer2 first, its match prescales the others
      for (int i = 2; i >= 0; i--) begin
         tk[i] = tick4;
         if (i < 2) begin
            if (q.t[i].outside_clock_select) begin
               tk[i] = rise[i];
            end else if (q.t[i].pre) begin
               tk[i] = tc[2];
            end
            rst_in[i] = !q.t[i].outside_clock_select && q.t[i].restart_on_input && rise[i];
         end
         // Active compare register
         cmp[i] = (q.t[i].dual_compare_select && q.t[i].compare_in_use) ?
                  q.t[i].cmpb : q.t[i].cmpa;
         // Match on the step into the compare value
         tc[i] = q.t[i].en && tk[i] && !rst_in[i] &&
                 (inc(q.t[i].cnt) == cmp[i]);
         if (q.t[i].en && rst_in[i]) begin
            d.t[i].cnt = `TCU_RST16;
         end else if (tc[i]) begin
            d.t[i].cnt = `TCU_RST16;
         end else if (q.t[i].en && tk[i]) begin
            d.t[i].cnt = inc(q.t[i].cnt);
         end
         d.t[i].tcp = tc[i];
         if (tc[i]) begin
            if (q.t[i].dual_compare_select) begin
               d.t[i].compare_in_use = !q.t[i].compare_in_use;
            end
            if (!q.t[i].repeat_run && (!q.t[i].dual_compare_select || q.t[i].compare_in_use)) begin
               d.t[i].en = 1'b0;
            end
         end
         // Request pulse, independent of later enable clear
         d.irq[i] = tc[i] && q.t[i].req;
      end

      // Register writes, taken at the acknowledge edge
      if (wr_now) begin
         for (int i = 0; i < 3; i++) begin
            if (idx == IX_CNT[i]) begin
               d.t[i].cnt = merge(q.t[i].cnt, wb_req.dat, wb_req.sel);
            end
            if (idx == IX_CMPA[i]) begin
               d.t[i].cmpa = merge(q.t[i].cmpa, wb_req.dat, wb_req.sel);
            end
            if (i < 2 && idx == IX_CMPB[i[0]]) begin
               d.t[i].cmpb = merge(q.t[i].cmpb, wb_req.dat, wb_req.sel);
            end
            if (idx == IX_CTL[i]) begin
               w = merge(ctl_rd(q.t[i]), wb_req.dat, wb_req.sel);
               if (w[`TCU_B_GATE]) begin
                  d.t[i].en = w[`TCU_B_EN];
               end
               d.t[i].req = w[`TCU_B_REQ];
               d.t[i].mc = w[`TCU_B_MC];
               d.t[i].repeat_run = w[`TCU_B_REPEAT_RUN];
               if (i < 2) begin
                  d.t[i].restart_on_input = w[`TCU_B_RTG];
                  d.t[i].pre = w[`TCU_B_PRE];
                  d.t[i].outside_clock_select = w[`TCU_B_EXT];
                  d.t[i].dual_compare_select = w[`TCU_B_ALT];
                  if (!w[`TCU_B_ALT]) begin
                     d.t[i].compare_in_use = 1'b0;
                  end
               end
            end
         end
      end

      // Terminal flag, a match beats a software clear
      for (int i = 0; i < 3; i++) begin
         if (tc[i]) begin
            d.t[i].mc = 1'b1;
         end
      end

      // Output pins follow the compare phase in dual compare, else pulse low for one cycle after a match
      for (int i = 0; i < 2; i++) begin
         d.tout[i] = d.t[i].dual_compare_select ? !d.t[i].compare_in_use : !tc[i];
      end

      // Bus phase and read data
      unique case (q.bus)
         tcu_pkg::TCU_BP_IDLE: begin
            d.ack = 1'b0;
            if (wb_req.cyc && wb_req.stb) begin
               for (int i = 0; i < 3; i++) begin
                  if (idx == IX_CNT[i]) begin
                     rd = q.t[i].cnt;
                  end
                  if (idx == IX_CMPA[i]) begin
                     rd = q.t[i].cmpa;
                  end
                  if (i < 2 && idx == IX_CMPB[i[0]]) begin
                     rd = q.t[i].cmpb;
                  end
                  if (idx == IX_CTL[i]) begin
                     rd = ctl_rd(q.t[i]);
                  end
               end
               d.dat = {16'h0000, rd};
               d.ack = 1'b1;
               d.bus = tcu_pkg::TCU_BP_ACK;
            end
         end
         tcu_pkg::TCU_BP_ACK: begin
            d.ack = 1'b0;
            d.bus = tcu_pkg::TCU_BP_IDLE;
         end
         default: begin
            d.ack = 1'b0;
            d.bus = tcu_pkg::TCU_BP_IDLE;
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.bus <= tcu_pkg::TCU_BP_IDLE;
         q.tout <= 2'h3;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;
   assign timer0_output = q.tout[0];
   assign timer1_output = q.tout[1];
   assign tmr_irq = q.irq;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   // Timer2 count step outside software writes
   sequence s_quiet_step;
      $changed(q.t[2].cnt) && !$past(wr_now);
   endsequence

   // Ungated control write leaves enable alone
   a_gate_hold: assert property (
      wr_now && idx == IX_CTL[1] && !wb_req.dat[`TCU_B_GATE] && !tc[1]
      |=> q.t[1].en == $past(q.t[1].en))
      else $error("enable changed without gate");

   // Control read shows gate as zero
   a_gate_reads: assert property (
      q.ack && $past(idx) == IX_CTL[1] |-> !q.dat[`TCU_B_GATE])
      else $error("gate bit read as one");

   // Stopped timer holds its count
   a_hold_off: assert property (
      !q.t[1].en && !wr_now |=> $stable(q.t[1].cnt))
      else $error("count moved while disabled");

   // Terminal with request enabled pulses irq
   a_irq_raise: assert property (
      q.t[0].tcp && $past(q.t[0].req) |-> q.irq[0])
      else $error("missing timer interrupt");

   // No request pulse without cause
   a_irq_cause: assert property (
      q.irq[2] |-> q.t[2].tcp && $past(q.t[2].req))
      else $error("spurious timer interrupt");

   // Match sets the terminal flag
   a_mc_set: assert property (
      tc[1] |=> q.t[1].mc)
      else $error("terminal flag not set");

   // Match clears the count
   a_cnt_clear: assert property (
      tc[0] && !wr_now |=> q.t[0].cnt == `TCU_RST16)
      else $error("count not cleared at match");

   // Dual compare flips the phase
   a_riu_flip: assert property (
      tc[1] && q.t[1].dual_compare_select && !wr_now
      |=> q.t[1].compare_in_use != $past(q.t[1].compare_in_use))
      else $error("compare phase not toggled");

   // One-shot clears enable at the end
   a_one_shot: assert property (
      tc[2] && !q.t[2].repeat_run && !wr_now |=> !q.t[2].en)
      else $error("one-shot timer kept running");

   // Timer2 steps only on the fourth cycle
   a_div_four: assert property (
      s_quiet_step |-> $past(q.div) == `TCU_DIV_LAST)
      else $error("timer2 stepped off divider");

   // Output pin tracks the phase in dual mode
   a_out_phase: assert property (
      q.t[1].dual_compare_select |-> timer1_output == !q.t[1].compare_in_use)
      else $error("output not following phase");

   // Prescaled timer steps on timer2 match
   a_prescale: assert property (
      tc[2] && q.t[0].en && q.t[0].pre && !q.t[0].outside_clock_select &&
      !q.t[0].restart_on_input && !tc[0] && !wr_now
      |=> q.t[0].cnt == inc($past(q.t[0].cnt)))
      else $error("prescaled step missing");

endmodule : tcu_timers
`default_nettype wire

// file: tb/tcu_timers_tb.sv
/*
 Self-checking bench for the three-channel maxcount timer block.
 Assumes the shared package and header on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tcu_defs.svh"
module tcu_timers_tb;
   // Row: register index, value written, value read back
   typedef struct packed {logic [6:0] ix; logic [15:0] wd; logic [15:0] ex;} tcu_row_s;
   logic clock;
   logic nrst;
   tcu_pkg::tcu_wbreq_s wb_req;
   logic wb_ack_o;
   logic [`TCU_DW-1:0] wb_dat_o;
   logic timer0_input;
   logic timer1_input;
   logic timer0_output;
   logic timer1_output;
   logic [`TCU_NT-1:0] tmr_irq;
   logic [31:0] rd;
   logic [31:0] r1;
   int n_errors;
   int checked;
   int cycles;
   int n_irq2;
   int snap;
   int gap;
   tcu_row_s rows [0:12] = '{
      '{`TCU_IX_CMPA0, 16'h1234, 16'h1234}, '{`TCU_IX_CMPB0, 16'habcd, 16'habcd},
      '{`TCU_IX_CMPA1, 16'h0f0f, 16'h0f0f}, '{`TCU_IX_CMPB1, 16'hf0f0, 16'hf0f0},
      '{`TCU_IX_CMPA2, 16'h5a5a, 16'h5a5a}, '{`TCU_IX_CNT2, 16'h00ff, 16'h00ff},
      '{`TCU_IX_CNT0, 16'h0007, 16'h0007}, '{`TCU_IX_CTL1, 16'h8001, 16'h0001},
      '{`TCU_IX_CTL1, 16'hc000, 16'h8000}, '{`TCU_IX_CTL1, 16'h0000, 16'h8000},
      '{`TCU_IX_CTL1, 16'h4000, 16'h0000}, '{`TCU_IX_CTL2, 16'h001e, 16'h0000},
      '{7'h70, 16'hffff, 16'h0000}};

   tcu_timers u_dut (
      .clock(clock),
      .nrst(nrst),
      .wb_req(wb_req),
      .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o),
      .timer0_input(timer0_input),
      .timer1_input(timer1_input),
      .timer0_output(timer0_output),
      .timer1_output(timer1_output),
      .tmr_irq(tmr_irq)
   );

   // ----------------------------------------
   // Clock, cycle ceiling, request counter
   // ----------------------------------------
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (tmr_irq[2] === 1'b1) n_irq2++;
      if (cycles == 20000) begin
         n_errors++;
         finish_test();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // Counts a compare and reports a mismatch
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] ex);
      checked++;
      if (seen !== ex) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, ex, seen);
      end
   endtask : check
   // One classic Wishbone cycle, held until ack
   task automatic bus(input logic we, input logic [6:0] ix, input logic [15:0] wd, output logic [31:0] d);
      @(posedge clock);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {ix, 2'b00}, sel: 4'h3, dat: {16'h0, wd}};
      do @(posedge clock); while (wb_ack_o !== 1'b1);
      d = wb_dat_o;
      wb_req <= '0;
   endtask : bus
   task automatic wr(input logic [6:0] ix, input logic [15:0] wd);
      bus(1'b1, ix, wd, rd);
   endtask : wr
   task automatic rdc(input logic [6:0] ix, input logic [31:0] ex, input string what);
      bus(1'b0, ix, 16'h0, rd);
      check(what, rd, ex);
   endtask : rdc
   // Count difference over a fixed spacing of reads
   task automatic span(input logic [6:0] ix, input int n, input logic [31:0] ex, input string what);
      bus(1'b0, ix, 16'h0, r1);
      repeat (n) @(posedge clock);
      bus(1'b0, ix, 16'h0, rd);
      check(what, rd - r1, ex);
   endtask : span
   // Cycles up to the next request pulse
   task automatic wait_irq(input int i, output int g);
      g = 0;
      do begin
         @(posedge clock);
         g++;
      end while (tmr_irq[i] !== 1'b1);
   endtask : wait_irq
   // One rising edge on a timer input pin
   task automatic rise(input int i);
      if (i == 0) timer0_input <= 1'b1;
      else timer1_input <= 1'b1;
      repeat (3) @(posedge clock);
      timer0_input <= 1'b0;
      timer1_input <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : rise
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      wb_req = '0;
      timer0_input = 1'b0;
      timer1_input = 1'b0;
      repeat (4) @(posedge clock);
      check("out0 in reset", {31'h0, timer0_output}, 32'h1);
      check("irq in reset", {29'h0, tmr_irq}, 32'h0);
      nrst <= 1'b1;
      foreach (rows[i]) rdc(rows[i].ix, 32'h0, "reset value");
      foreach (rows[i]) begin
         wr(rows[i].ix, rows[i].wd);
         rdc(rows[i].ix, {16'h0, rows[i].ex}, "read back");
      end
      // Internal clock rate, then hold when disabled
      wr(`TCU_IX_CMPA0, 16'h0);
      wr(`TCU_IX_CNT0, 16'h0);
      wr(`TCU_IX_CTL0, 16'hc001);
      span(`TCU_IX_CNT0, 37, 32'ha, "step rate");
      wr(`TCU_IX_CTL0, 16'h4000);
      span(`TCU_IX_CNT0, 37, 32'h0, "held count");
      // Single compare with requests, count restarted below the compare
      wr(`TCU_IX_CMPA0, 16'h3);
      wr(`TCU_IX_CNT0, 16'h0);
      wr(`TCU_IX_CTL0, 16'he001);
      wait_irq(0, gap);
      wait_irq(0, gap);
      check("single gap", gap, 32'hc);
      rdc(`TCU_IX_CTL0, 32'ha021, "flag set");
      wr(`TCU_IX_CTL0, 16'h4000);
      // Dual compare: A of 2 ticks, B of 5 ticks
      wr(`TCU_IX_CMPA1, 16'h2);
      wr(`TCU_IX_CMPB1, 16'h5);
      wr(`TCU_IX_CNT1, 16'h0);
      wr(`TCU_IX_CTL1, 16'he003);
      wait_irq(1, gap);
      for (int k = 0; k < 4; k++) begin
         wait_irq(1, gap);
         check("dual gap", gap, k[0] ? 32'h8 : 32'h14);
         check("dual out", {31'h0, timer1_output}, {31'h0, ~k[0]});
      end
      check("b phase out", {31'h0, timer1_output}, 32'h0);
      rdc(`TCU_IX_CTL1, 32'hb023, "b in use");
      wr(`TCU_IX_CTL1, 16'h4000);
      // Outside clock, prescale bit set but ignored
      wr(`TCU_IX_CNT0, 16'h0);
      wr(`TCU_IX_CMPA0, 16'h0);
      wr(`TCU_IX_CTL0, 16'hc00d);
      repeat (5) rise(0);
      rdc(`TCU_IX_CNT0, 32'h5, "outside steps");
      wr(`TCU_IX_CTL0, 16'h4000);
      // Restart on input edge
      wr(`TCU_IX_CMPA1, 16'h0);
      wr(`TCU_IX_CNT1, 16'h0);
      wr(`TCU_IX_CTL1, 16'hc011);
      repeat (40) @(posedge clock);
      rise(1);
      bus(1'b0, `TCU_IX_CNT1, 16'h0, rd);
      check("restart", {31'h0, rd < 32'h4}, 32'h1);
      wr(`TCU_IX_CTL1, 16'h4000);
      // Timer2 as prescaler of timer0
      wr(`TCU_IX_CNT2, 16'h0);
      wr(`TCU_IX_CMPA2, 16'h2);
      wr(`TCU_IX_CTL2, 16'hffdf);
      bus(1'b0, `TCU_IX_CTL2, 16'h0, rd);
      check("reduced ctl", rd & 32'hffdf, 32'ha001);
      wr(`TCU_IX_CNT0, 16'h0);
      wr(`TCU_IX_CTL0, 16'hc009);
      span(`TCU_IX_CNT0, 77, 32'ha, "prescaled");
      // One-shot without requests
      wr(`TCU_IX_CTL2, 16'h4000);
      wr(`TCU_IX_CNT2, 16'h0);
      wr(`TCU_IX_CMPA2, 16'h3);
      snap = n_irq2;
      wr(`TCU_IX_CTL2, 16'hc000);
      repeat (60) @(posedge clock);
      rdc(`TCU_IX_CTL2, 32'h0020, "one shot");
      check("no request", n_irq2 - snap, 32'h0);
      // Reset in mid-run
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      rdc(`TCU_IX_CTL0, 32'h0, "ctl after reset");
      rdc(`TCU_IX_CNT0, 32'h0, "count after reset");
      finish_test();
   end
endmodule : tcu_timers_tb
`default_nettype wire
